// ---- stcb_defs.svh ----
`ifndef STCB_DEFS_SVH
`define STCB_DEFS_SVH
// register byte offsets
`define STCB_OFS_CTRL 8'h00
`define STCB_OFS_STATUS 8'h04
`define STCB_OFS_BASE 8'h08
`define STCB_OFS_SIZE 8'h0C
`define STCB_OFS_WPTR 8'h10
`define STCB_OFS_WMARK 8'h14
`define STCB_OFS_SRCID 8'h18
`define STCB_OFS_TSFREQ 8'h1C
`define STCB_OFS_STIMCTL 8'h20
`define STCB_OFS_TSLO 8'h24
`define STCB_OFS_TSHI 8'h28
`define STCB_OFS_SECMST 8'h2C
`define STCB_OFS_LPIID 8'h30
`define STCB_OFS_STIMID 8'h34
// control register bit positions
`define STCB_CTL_EN 0
`define STCB_CTL_CIRC 1
`define STCB_CTL_SCAT 2
`define STCB_CTL_STOPTRIG 3
`define STCB_CTL_TRIGPACK 4
`define STCB_CTL_LPIEN 5
`define STCB_CTL_SPIEN 6
`define STCB_CTL_TWOSTAGE 7
`define STCB_CTL_NS 8
`define STCB_CTL_W 9
`define STCB_CTL_RST 9'h100
// status register bit positions
`define STCB_ST_WRAP 0
`define STCB_ST_WM 1
`define STCB_ST_TRIG 2
`define STCB_ST_STOP 3
`define STCB_ST_DROP 4
`define STCB_ST_FULL 5
// stimulus control register bit positions
`define STCB_SC_SYNC_EN 0
`define STCB_SC_COMPR 1
`define STCB_SC_MULTI 2
`define STCB_SC_ARM 3
`define STCB_SC_SHARED 4
// stimulus unit shape
`define STCB_NUM_MASTERS 2
`define STCB_PORTS_PER_MASTER 16'h4000
`define STCB_FUND_BITS 8'h40
`define STCB_SHARED_MASTER 1'b1
// trace stream constants
`define STCB_TRIG_ID 7'h7D
`define STCB_WORD_BYTES 32'h8
`define STCB_SRCID_RST 7'h10
`define STCB_TSFREQ_RST 32'h017D7840
`define STCB_SIZE_RST 32'h00001000
`endif

// ---- stcb_pkg.sv ----
`include "stcb_defs.svh"
package stcb_pkg;
   typedef enum logic [1:0] {
      STCB_IDLE = 2'b00,
      STCB_RUN = 2'b01,
      STCB_STOP = 2'b10
   } stcb_state_t;

   typedef struct packed {
      stcb_state_t st;
      logic [`STCB_CTL_W-1:0] ctrl;
      logic [31:0] base;
      logic [31:0] size;
      logic [31:0] wmark;
      logic [6:0] src_id;
      logic [31:0] ts_freq;
      logic compress;
      logic trig_multi;
      logic trig_armed;
      logic [`STCB_NUM_MASTERS-1:0] sec_master;
      logic [15:0] msi_id;
      logic [31:0] wptr;
      logic [31:0] fill;
      logic f_wrap;
      logic f_wm;
      logic f_trig;
      logic f_drop;
      logic f_full;
      logic [63:0] ts;
      logic out_valid;
      logic [31:0] out_addr;
      logic [63:0] out_data;
      logic out_xlat;
      logic [1:0] out_stages;
      logic out_ns;
      logic msi_req;
      logic [31:0] rdata;
      logic trig_s1;
      logic trig_s2;
      logic trig_s3;
      logic stim_trig;
   } stcb_regs_t;
endpackage : stcb_pkg

// ---- stcb_capture.sv ----
// The register addresses and the strobed register port were chosen for this implementation.
`include "stcb_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module stcb_capture (
   input wire logic clk,
   input wire logic rstn,
   // register bus, same clock as the block
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_secure,
   output logic [31:0] bus_rdata,
   // trace stream from the funnels, valid/ready
   input wire logic trace_valid,
   output logic trace_ready,
   input wire logic [6:0] trace_id,
   input wire logic [31:0] trace_data,
   // trigger pin is asynchronous, the generator request is same-clock
   input wire logic trig_pin,
   input wire logic stim_trig_req,
   output logic stim_trig_out,
   // one-word write port toward the memory interconnect
   output logic mem_wr_valid,
   input wire logic mem_wr_ready,
   output logic [31:0] mem_wr_addr,
   output logic [63:0] mem_wr_data,
   output logic mem_wr_xlat,
   output logic [1:0] mem_wr_stages,
   output logic mem_wr_ns,
   // interrupt outputs and the secure master set
   output logic irq_spi,
   output logic msi_req,
   output logic [15:0] msi_id,
   output logic [`STCB_NUM_MASTERS-1:0] sec_master
);
   stcb_pkg::stcb_regs_t s_r;
   stcb_pkg::stcb_regs_t s_nxt;

   // register read mux; unmapped offsets read zero
   function automatic logic [31:0] reg_read(input stcb_pkg::stcb_regs_t s,
                                            input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      unique case (a)
         `STCB_OFS_CTRL: v[`STCB_CTL_W-1:0] = s.ctrl;
         // sticky flags plus the live stopped state, which software cannot clear
         `STCB_OFS_STATUS: begin
            v[`STCB_ST_WRAP] = s.f_wrap;
            v[`STCB_ST_WM] = s.f_wm;
            v[`STCB_ST_TRIG] = s.f_trig;
            v[`STCB_ST_STOP] = (s.st == stcb_pkg::STCB_STOP);
            v[`STCB_ST_DROP] = s.f_drop;
            v[`STCB_ST_FULL] = s.f_full;
         end
         `STCB_OFS_BASE: v = s.base;
         `STCB_OFS_SIZE: v = s.size;
         `STCB_OFS_WPTR: v = s.wptr;
         `STCB_OFS_WMARK: v = s.wmark;
         `STCB_OFS_SRCID: v[6:0] = s.src_id;
         `STCB_OFS_TSFREQ: v = s.ts_freq;
         // fixed bits of the stimulus control read back as constants
         `STCB_OFS_STIMCTL: begin
            v[`STCB_SC_SYNC_EN] = 1'b1; // hard-wired, writes ignored
            v[`STCB_SC_COMPR] = s.compress;
            v[`STCB_SC_MULTI] = s.trig_multi;
            v[`STCB_SC_ARM] = s.trig_armed;
            v[`STCB_SC_SHARED] = `STCB_SHARED_MASTER;
         end
         // halves are read apart, so software must guard against the carry
         `STCB_OFS_TSLO: v = s.ts[31:0];
         `STCB_OFS_TSHI: v = s.ts[63:32];
         `STCB_OFS_SECMST: v[`STCB_NUM_MASTERS-1:0] = s.sec_master;
         `STCB_OFS_LPIID: v[15:0] = s.msi_id;
         // fixed shape of the stimulus unit; nothing here is writable
         `STCB_OFS_STIMID: begin
            v[7:0] = 8'(`STCB_NUM_MASTERS);
            v[15:8] = `STCB_FUND_BITS;
            v[31:16] = `STCB_PORTS_PER_MASTER;
         end
         default: v = 32'h0;
      endcase
      return v;
   endfunction : reg_read

   // one stored word moves a byte position by the word size; pointer and fill share it
   function automatic logic [31:0] advance(input logic [31:0] x);
      return x + `STCB_WORD_BYTES;
   endfunction : advance

   // next-state logic for the whole block
   always_comb begin
      logic pin_evt;
      logic take;
      logic is_trig;
      logic trig_evt;
      logic store;
      logic [31:0] nptr;
      logic [31:0] nfill;
      logic new_irq;
      pin_evt = 1'b0;
      take = 1'b0;
      is_trig = 1'b0;
      trig_evt = 1'b0;
      store = 1'b0;
      nptr = 32'h0;
      nfill = 32'h0;
      new_irq = 1'b0;
      s_nxt = s_r;
      s_nxt.msi_req = 1'b0;
      s_nxt.stim_trig = 1'b0;
      s_nxt.rdata = 32'h0;
      // free-running absolute timestamp
      s_nxt.ts = s_r.ts + 64'h1;

      // trigger pin synchroniser; only the second and third stages are compared
      s_nxt.trig_s1 = trig_pin;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_s3 = s_r.trig_s2;
      pin_evt = s_r.trig_s2 & ~s_r.trig_s3;

      // trigger generation: single-shot disarms, multi-shot stays armed
      if (stim_trig_req && s_r.trig_armed) begin
         s_nxt.stim_trig = 1'b1;
         if (!s_r.trig_multi) begin
            s_nxt.trig_armed = 1'b0;
         end
      end

      // memory write slot drains when the interconnect takes it
      if (s_r.out_valid && mem_wr_ready) begin
         s_nxt.out_valid = 1'b0;
      end

      // register reads answer in the next cycle only
      if (bus_rd) begin
         s_nxt.rdata = reg_read(s_r, bus_addr);
      end

      // register writes go first so that hardware sets below win over clears
      if (bus_wr) begin
         unique case (bus_addr)
            // a rising enable restarts at the region base; program geometry first
            `STCB_OFS_CTRL: begin
               s_nxt.ctrl = bus_wdata[`STCB_CTL_W-1:0];
               if (bus_wdata[`STCB_CTL_EN] && !s_r.ctrl[`STCB_CTL_EN]) begin
                  s_nxt.st = stcb_pkg::STCB_RUN;
                  s_nxt.wptr = 32'h0;
                  s_nxt.fill = 32'h0;
                  s_nxt.f_full = 1'b0;
               end else if (!bus_wdata[`STCB_CTL_EN]) begin
                  s_nxt.st = stcb_pkg::STCB_IDLE;
               end
            end
            `STCB_OFS_STATUS: begin
               // write one to clear
               if (bus_wdata[`STCB_ST_WRAP]) s_nxt.f_wrap = 1'b0;
               if (bus_wdata[`STCB_ST_WM]) s_nxt.f_wm = 1'b0;
               if (bus_wdata[`STCB_ST_TRIG]) s_nxt.f_trig = 1'b0;
               if (bus_wdata[`STCB_ST_DROP]) s_nxt.f_drop = 1'b0;
               if (bus_wdata[`STCB_ST_FULL]) s_nxt.f_full = 1'b0;
            end
            // geometry is used by the next word, so change it only while idle
            `STCB_OFS_BASE: s_nxt.base = bus_wdata; // any normal address
            `STCB_OFS_SIZE: s_nxt.size = bus_wdata;
            `STCB_OFS_WMARK: s_nxt.wmark = bus_wdata;
            `STCB_OFS_SRCID: s_nxt.src_id = bus_wdata[6:0];
            `STCB_OFS_TSFREQ: s_nxt.ts_freq = bus_wdata;
            // sync enable is not stored: it always reads one
            `STCB_OFS_STIMCTL: begin
               s_nxt.compress = bus_wdata[`STCB_SC_COMPR];
               s_nxt.trig_multi = bus_wdata[`STCB_SC_MULTI];
               s_nxt.trig_armed = bus_wdata[`STCB_SC_ARM];
            end
            `STCB_OFS_SECMST: begin
               // non-secure writes are silently dropped
               if (bus_secure) begin
                  s_nxt.sec_master = bus_wdata[`STCB_NUM_MASTERS-1:0];
               end
            end
            // message interrupt id, sent beside each message pulse
            `STCB_OFS_LPIID: s_nxt.msi_id = bus_wdata[15:0];
            default: begin
            end
         endcase
      end

      // trace intake; outside a run the stream is drained and discarded
      take = trace_valid && trace_ready;
      is_trig = (trace_id == `STCB_TRIG_ID);
      trig_evt = s_r.stim_trig | pin_evt | (take & is_trig);
      if (take && s_r.st == stcb_pkg::STCB_RUN) begin
         if (is_trig) begin
            store = s_r.ctrl[`STCB_CTL_TRIGPACK]; // pack or ignore
         end else if (trace_id == s_r.src_id) begin
            store = 1'b1;
         end else begin
            s_nxt.f_drop = 1'b1; // processor trace never lands
         end
      end

      if (store) begin
         s_nxt.out_valid = 1'b1;
         // scatter mode sends the offset for translation, else physical
         if (s_r.ctrl[`STCB_CTL_SCAT]) begin
            s_nxt.out_addr = s_r.wptr;
            s_nxt.out_stages = s_r.ctrl[`STCB_CTL_TWOSTAGE] ? 2'b11 : 2'b01;
         end else begin
            s_nxt.out_addr = s_r.base + s_r.wptr;
            s_nxt.out_stages = 2'b00;
         end
         s_nxt.out_xlat = s_r.ctrl[`STCB_CTL_SCAT];
         s_nxt.out_ns = s_r.ctrl[`STCB_CTL_NS];
         // each word carries its source id so streams can be separated
         s_nxt.out_data = {24'h0, is_trig, trace_id, trace_data};
         // wrap or stop is decided on the position after this word
         nptr = advance(s_r.wptr);
         if (nptr >= s_r.size) begin
            if (s_r.ctrl[`STCB_CTL_CIRC]) begin
               s_nxt.wptr = 32'h0; // same cycle as the wrap flag
               s_nxt.f_wrap = 1'b1;
               new_irq = 1'b1;
            end else begin
               s_nxt.wptr = nptr;
               s_nxt.f_full = 1'b1;
               s_nxt.st = stcb_pkg::STCB_STOP;
            end
         end else begin
            s_nxt.wptr = nptr;
         end
         // fill level saturates at the region size once it has wrapped
         nfill = (s_r.fill < s_r.size) ? advance(s_r.fill) : s_r.fill;
         s_nxt.fill = nfill;
         if (nfill == s_r.wmark && s_r.fill != s_r.wmark) begin
            s_nxt.f_wm = 1'b1;
            new_irq = 1'b1;
         end
      end

      // a trigger during a run is logged and may end capture
      if (trig_evt && s_r.st == stcb_pkg::STCB_RUN) begin
         s_nxt.f_trig = 1'b1;
         if (s_r.ctrl[`STCB_CTL_STOPTRIG]) begin
            s_nxt.st = stcb_pkg::STCB_STOP;
         end
      end

      // message interrupt is one pulse per store that wraps or reaches the watermark, even when one store does both
      s_nxt.msi_req = new_irq & s_r.ctrl[`STCB_CTL_LPIEN];
   end

   // only the block reset clears state; a processor warm reset never reaches here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '{st: stcb_pkg::STCB_IDLE,
                  ctrl: `STCB_CTL_RST,
                  base: 32'h0,
                  size: `STCB_SIZE_RST,
                  wmark: 32'h0,
                  src_id: `STCB_SRCID_RST,
                  ts_freq: `STCB_TSFREQ_RST,
                  compress: 1'b0,
                  trig_multi: 1'b0,
                  trig_armed: 1'b0,
                  sec_master: '0,
                  msi_id: 16'h0,
                  wptr: 32'h0,
                  fill: 32'h0,
                  f_wrap: 1'b0,
                  f_wm: 1'b0,
                  f_trig: 1'b0,
                  f_drop: 1'b0,
                  f_full: 1'b0,
                  ts: 64'h0,
                  out_valid: 1'b0,
                  out_addr: 32'h0,
                  out_data: 64'h0,
                  out_xlat: 1'b0,
                  out_stages: 2'b00,
                  out_ns: 1'b1,
                  msi_req: 1'b0,
                  rdata: 32'h0,
                  trig_s1: 1'b0,
                  trig_s2: 1'b0,
                  trig_s3: 1'b0,
                  stim_trig: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // the slot holds one word; back-pressure only while running
   assign trace_ready = (s_r.st != stcb_pkg::STCB_RUN) || !s_r.out_valid || mem_wr_ready;
   assign bus_rdata = s_r.rdata;
   assign stim_trig_out = s_r.stim_trig;
   // the write port is the slot itself, so it stands still while stalled
   assign mem_wr_valid = s_r.out_valid;
   assign mem_wr_addr = s_r.out_addr;
   assign mem_wr_data = s_r.out_data;
   assign mem_wr_xlat = s_r.out_xlat;
   assign mem_wr_stages = s_r.out_stages;
   assign mem_wr_ns = s_r.out_ns;
   // wired interrupt is a level from the wrap and watermark sticky flags
   assign irq_spi = s_r.ctrl[`STCB_CTL_SPIEN] & (s_r.f_wrap | s_r.f_wm);
   // message interrupt and its id come straight from registers
   assign msi_req = s_r.msi_req;
   assign msi_id = s_r.msi_id;
   assign sec_master = s_r.sec_master;
endmodule : stcb_capture
`default_nettype wire

// ---- stcb_capture_chk.sv ----
`include "stcb_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module stcb_capture_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_secure,
   input wire logic [31:0] bus_rdata,
   input wire logic trace_ready,
   input wire logic stim_trig_req,
   input wire logic stim_trig_out,
   input wire logic mem_wr_valid,
   input wire logic mem_wr_ready,
   input wire logic [63:0] mem_wr_data,
   input wire logic [31:0] mem_wr_addr,
   input wire logic [1:0] mem_wr_stages,
   input wire logic [15:0] msi_id,
   input wire logic [`STCB_NUM_MASTERS-1:0] sec_master
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // a stalled word must not move, or memory would see a torn write
   sequence s_stall;
      mem_wr_valid && !mem_wr_ready;
   endsequence
   sequence s_held;
      mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
   endsequence
   AST_MEM_HOLD: assert property (s_stall |=> s_held)
      else $error("stalled memory word changed");
   AST_READY_LOW: assert property (!trace_ready |-> s_stall)
      else $error("trace input refused without a stall");
   AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
      else $error("read data outside its cycle");
   AST_TRIG_CAUSE: assert property (stim_trig_out |-> $past(stim_trig_req))
      else $error("trigger pulse without request");
   AST_PACK_ZERO: assert property (mem_wr_valid |-> mem_wr_data[63:40] == 24'h0)
      else $error("stored word upper bits not zero");
   AST_TRIG_FLAG: assert property (mem_wr_valid |->
      mem_wr_data[39] == (mem_wr_data[38:32] == `STCB_TRIG_ID))
      else $error("trigger flag does not match source id");
   AST_STAGES: assert property (mem_wr_valid |-> mem_wr_stages != 2'b10)
      else $error("illegal stage code");
   AST_SECM: assert property ($changed(sec_master) |-> $past(bus_wr && bus_secure))
      else $error("secure master set changed without secure write");
   AST_MSI_ID: assert property (!$past(bus_wr) |-> $stable(msi_id))
      else $error("message id changed without write");
endmodule : stcb_capture_chk
bind stcb_capture stcb_capture_chk u_chk (.clk(clk), .rstn(rstn), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_secure(bus_secure), .bus_rdata(bus_rdata),
   .trace_ready(trace_ready), .stim_trig_req(stim_trig_req), .stim_trig_out(stim_trig_out),
   .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data),
   .mem_wr_addr(mem_wr_addr), .mem_wr_stages(mem_wr_stages), .msi_id(msi_id),
   .sec_master(sec_master));
`default_nettype wire

// ---- stcb_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module stcb_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic stall_en,
   output logic mem_wr_ready
);
   integer seed = 75697;
   // random back-pressure exercises the hold path of the write port
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_wr_ready <= 1'b0;
      end else begin
         mem_wr_ready <= !stall_en || (($random(seed) & 32'h1) == 32'h0);
      end
   end
endmodule : stcb_mem_model
`default_nettype wire

// ---- tb_top.sv ----
`include "stcb_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0, bus_rd = 1'b0, bus_secure = 1'b0, trace_valid = 1'b0;
   logic [6:0] trace_id = 7'h00;
   logic [31:0] trace_data = 32'h0;
   logic trig_pin = 1'b0, stim_trig_req = 1'b0, stall_en = 1'b0, rd_seen = 1'b0;
   logic trace_ready, stim_trig_out, mem_wr_valid, mem_wr_ready, mem_wr_xlat, mem_wr_ns;
   logic irq_spi, msi_req, scat, two;
   logic [31:0] bus_rdata, mem_wr_addr, base_v, size_v, wp, d;
   logic [63:0] mem_wr_data;
   logic [1:0] mem_wr_stages;
   logic [15:0] msi_id;
   logic [`STCB_NUM_MASTERS-1:0] sec_master;
   logic [31:0] rq[$];
   logic [99:0] mq[$];
   int mismatches = 0, n_tests = 0, n_msi = 0, n_trig = 0, i;
   integer seed = 75697;

   always #20 clk = ~clk;

   stcb_capture u_dut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_secure(bus_secure), .bus_rdata(bus_rdata),
      .trace_valid(trace_valid), .trace_ready(trace_ready), .trace_id(trace_id),
      .trace_data(trace_data), .trig_pin(trig_pin), .stim_trig_req(stim_trig_req),
      .stim_trig_out(stim_trig_out), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_xlat(mem_wr_xlat),
      .mem_wr_stages(mem_wr_stages), .mem_wr_ns(mem_wr_ns), .irq_spi(irq_spi),
      .msi_req(msi_req), .msi_id(msi_id), .sec_master(sec_master));
   stcb_mem_model u_mem (.clk(clk), .rstn(rstn), .stall_en(stall_en),
      .mem_wr_ready(mem_wr_ready));

   task automatic chk(input logic [99:0] got, input logic [99:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic sec = 1'b0);
      bus_addr <= a;
      bus_wdata <= v;
      bus_secure <= sec;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
   endtask : rd

   // offered word is held until the edge that sees ready
   task automatic send(input logic [6:0] id, input logic [31:0] v, input logic st);
      if (st) begin
         mq.push_back({scat ? wp : base_v + wp, 24'h0, id == `STCB_TRIG_ID, id, v, scat,
            {scat & two, scat}, 1'b1});
         wp = (wp + 32'h8 >= size_v) ? 32'h0 : wp + 32'h8;
      end
      trace_valid <= 1'b1;
      trace_id <= id;
      trace_data <= v;
      do @(posedge clk); while (!trace_ready);
   endtask : send

   task automatic pulse;
      stim_trig_req <= 1'b1;
      @(posedge clk);
      stim_trig_req <= 1'b0;
      @(posedge clk);
   endtask : pulse

   task automatic drain;
      int k;
      trace_valid <= 1'b0;
      for (k = 0; k < 300 && mq.size() != 0; k++) @(posedge clk);
      chk(100'(mq.size()), 100'h0);
   endtask : drain

   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   // outputs are settled at the falling edge; oldest note is compared
   always @(negedge clk) begin
      if (rd_seen) begin
         chk({68'h0, bus_rdata}, {68'h0, rq.pop_front()});
      end
      rd_seen = bus_rd;
      if (mem_wr_valid && mem_wr_ready) begin
         chk({mem_wr_addr, mem_wr_data, mem_wr_xlat, mem_wr_stages, mem_wr_ns},
             mq.pop_front());
      end
      n_msi += int'(msi_req);
      n_trig += int'(stim_trig_out);
   end

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(`STCB_OFS_CTRL, 32'h100);
      rd(`STCB_OFS_SIZE, `STCB_SIZE_RST);
      rd(`STCB_OFS_TSFREQ, `STCB_TSFREQ_RST);
      rd(`STCB_OFS_STIMID, 32'h4000_4002);
      rd(`STCB_OFS_TSHI, 32'h0);
      rd(8'h3C, 32'h0);
      wr(`STCB_OFS_TSFREQ, 32'h1234_5678);
      rd(`STCB_OFS_TSFREQ, 32'h1234_5678);
      wr(`STCB_OFS_STIMCTL, 32'h2);
      rd(`STCB_OFS_STIMCTL, 32'h13);
      wr(`STCB_OFS_SECMST, 32'h1, 1'b0);
      wr(`STCB_OFS_SECMST, 32'h2, 1'b1);
      rd(`STCB_OFS_SECMST, 32'h2);
      wr(`STCB_OFS_STIMCTL, 32'h8);
      pulse();
      pulse();
      wr(`STCB_OFS_STIMCTL, 32'hC);
      pulse();
      pulse();
      chk(100'(n_trig), 100'h3);
      base_v = 32'h8000_0004;
      size_v = 32'h40;
      scat = 1'b0;
      wp = 32'h0;
      wr(`STCB_OFS_BASE, base_v);
      wr(`STCB_OFS_SIZE, size_v);
      wr(`STCB_OFS_WMARK, 32'h20);
      wr(`STCB_OFS_LPIID, 32'h00A5);
      stall_en <= 1'b1;
      wr(`STCB_OFS_CTRL, 32'h163); // path opened before any trace flows
      for (i = 0; i < 10; i++) begin
         d = $random(seed);
         send(`STCB_SRCID_RST, d, 1'b1);
         if (i == 5) send(7'h22, d, 1'b0);
      end
      drain();
      rd(`STCB_OFS_STATUS, 32'h13);
      #1 chk({99'h0, irq_spi}, 100'h1);
      chk(100'(n_msi), 100'h2);
      chk({84'h0, msi_id}, 100'hA5);
      chk({98'h0, sec_master}, 100'h2);
      wr(`STCB_OFS_STATUS, 32'h13);
      #1 chk({99'h0, irq_spi}, 100'h0);
      wr(`STCB_OFS_CTRL, 32'h100);
      wr(`STCB_OFS_CTRL, 32'h119);
      wp = 32'h0;
      send(`STCB_SRCID_RST, 32'hA, 1'b1);
      send(`STCB_TRIG_ID, 32'hB, 1'b1);
      send(`STCB_SRCID_RST, 32'hC, 1'b0);
      drain();
      rd(`STCB_OFS_STATUS, 32'hC);
      wr(`STCB_OFS_STATUS, 32'hC);
      wr(`STCB_OFS_CTRL, 32'h100);
      wr(`STCB_OFS_CTRL, 32'h185);
      scat = 1'b1;
      two = 1'b1;
      wp = 32'h0;
      send(`STCB_SRCID_RST, $random(seed), 1'b1);
      send(`STCB_SRCID_RST, $random(seed), 1'b1);
      drain();
      wr(`STCB_OFS_CTRL, 32'h100);
      wr(`STCB_OFS_CTRL, 32'h105);
      two = 1'b0;
      wp = 32'h0;
      send(`STCB_SRCID_RST, $random(seed), 1'b1);
      drain();
      trig_pin <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`STCB_OFS_STATUS, 32'h4);
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
